//--- src/lane_pattern_gate.sv
// Gates one lane's pattern code by the per-lane selection control.
// Assumes the selection control is a registered level.
`timescale 1ns/100ps
module lane_pattern_gate
  import lane_test_power_gain_pkg::*;
(
  input  wire logic          choose,
  input  wire pattern_code_t code_in,
  output      pattern_code_t code_out,
  output      logic          code_active
);
  assign code_active = choose;
  assign code_out    = choose ? code_in : 3'h0;
endmodule : lane_pattern_gate

//--- src/lane_test_power_gain_map.svh
// Offsets, field positions, reset values for the lane test, power and
// channel 9 gain/offset register slice.
// Assumes a 16-bit register port with byte-style register indices.
`ifndef LANE_TEST_POWER_GAIN_MAP_SVH
`define LANE_TEST_POWER_GAIN_MAP_SVH

`define ADDR_LANE_PATTERN_SELECT_7_8 8'h23
`define ADDR_CHAN_POWER_INVERT_5_8   8'h24
`define ADDR_CHAN9_GAIN_OFFSET       8'h25
`define ADDR_CHAN9_OFFSET_COPY       8'h26

`define RESET_REG_VALUE              16'h0000

`define LANE7_PAT_MSB                7
`define LANE7_PAT_LSB                5
`define LANE8_PAT_MSB                4
`define LANE8_PAT_LSB                2
`define DIG_SLEEP_MSB                15
`define DIG_SLEEP_LSB                12
`define OUT_SLEEP_MSB                11
`define OUT_SLEEP_LSB                8
`define ANA_SLEEP_MSB                7
`define ANA_SLEEP_LSB                4
`define FLIP_MSB                     3
`define FLIP_LSB                     0
`define GAIN_MSB                     15
`define GAIN_LSB                     11
`define OFFSET_MSB                   9
`define OFFSET_LSB                   0

// Gain step in hundredths of a dB per code
`define GAIN_STEP_CENTI_DB           20

`endif

//--- src/lane_test_power_gain_pkg.sv
// Types shared by the lane test, power and gain register slice.
// Assumes the map header supplies the numeric constants.
package lane_test_power_gain_pkg;
  typedef logic [2:0]        pattern_code_t;
  typedef logic [4:0]        gain_code_t;
  typedef logic signed [9:0] offset_t;
  typedef logic [3:0]        lane_vec_t;
  typedef logic [15:0]       reg_word_t;
endpackage : lane_test_power_gain_pkg

//--- src/lane_test_power_gain_regs.sv
// Register slice: lane 7/8 test pattern codes, channel 5-8 sleep and
// lane 5-8 inversion, channel 9 digital gain and duplicated offset.
// Assumes a synchronous register port; global enables come from
// registers outside this slice as plain inputs.
`timescale 1ns/100ps
`include "lane_test_power_gain_map.svh"

// Contract
// (R01) Bits 7-5 of pattern register choose the lane 7 test pattern.
// (R02) Bits 4-2 of pattern register choose the lane 8 test pattern.
// (R03) Pattern fields act only while per-lane pattern choose is one.
// (R04) Power bits 15-12 sleep digital blocks of channels 8 to 5.
// (R05) Power bits 11-8 sleep serial output lanes 8 to 5.
// (R06) Power bits 7-4 sleep analog blocks of channels 8 to 5.
// (R07) Power bits 3-0 invert sample data on lanes 8 to 5.
// (R08) All sleep and inversion bits reset to zero.
// (R09) Channel 9 gain bits 15-11 apply only while global gain is on.
// (R10) Applied gain is code times 0.2 dB.
// (R11) Channel 9 offset bits 9-0 apply only while global offset is on.
// (R12) Offset is a ten-bit signed twos-complement number.
// (R13) Software writes the same offset into the copy register.
// (R14) Software copies the offset back into the gain/offset register.
// (R15) Reserved bits are plain read-write storage; software writes zero.
module lane_test_power_gain_regs
  import lane_test_power_gain_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output      logic [DATA_W-1:0] reg_rdata,
  input  wire logic              per_lane_pattern_choose,
  input  wire logic              global_gain_apply,
  input  wire logic              global_offset_apply,
  output      pattern_code_t     lane7_pattern_code,
  output      pattern_code_t     lane8_pattern_code,
  output      logic              lane7_pattern_active,
  output      logic              lane8_pattern_active,
  output      lane_vec_t         digital_sleep,
  output      lane_vec_t         output_sleep,
  output      lane_vec_t         analog_sleep,
  output      lane_vec_t         polarity_flip,
  output      gain_code_t        chan9_gain_code,
  output      logic [9:0]        chan9_gain_centi_db,
  output      offset_t           chan9_offset_value,
  output      logic              chan9_offset_mismatch
);

  reg_word_t pattern_reg;
  reg_word_t power_reg;
  reg_word_t gain_offset_reg;
  reg_word_t offset_copy_reg;
  reg_word_t rdata_next;

  // Decode shared by the write and read paths
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  // Every bit, reserved ones included, is stored as written
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pattern_reg <= `RESET_REG_VALUE;
    end else if (clk_en && reg_write &&
                 hit(reg_addr, `ADDR_LANE_PATTERN_SELECT_7_8)) begin
      pattern_reg <= reg_wdata[15:0]; // R15
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      power_reg <= `RESET_REG_VALUE; // R08
    end else if (clk_en && reg_write &&
                 hit(reg_addr, `ADDR_CHAN_POWER_INVERT_5_8)) begin
      power_reg <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gain_offset_reg <= `RESET_REG_VALUE;
    end else if (clk_en && reg_write &&
                 hit(reg_addr, `ADDR_CHAN9_GAIN_OFFSET)) begin
      gain_offset_reg <= reg_wdata[15:0];
    end
  end

  // The copy is not mirrored by hardware; software keeps both equal
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      offset_copy_reg <= `RESET_REG_VALUE;
    end else if (clk_en && reg_write &&
                 hit(reg_addr, `ADDR_CHAN9_OFFSET_COPY)) begin
      offset_copy_reg <= reg_wdata[15:0]; // R13
    end
  end

  always_comb begin
    rdata_next = 16'h0000;
    if (hit(reg_addr, `ADDR_LANE_PATTERN_SELECT_7_8)) begin
      rdata_next = pattern_reg;
    end else if (hit(reg_addr, `ADDR_CHAN_POWER_INVERT_5_8)) begin
      rdata_next = power_reg;
    end else if (hit(reg_addr, `ADDR_CHAN9_GAIN_OFFSET)) begin
      rdata_next = gain_offset_reg;
    end else if (hit(reg_addr, `ADDR_CHAN9_OFFSET_COPY)) begin
      rdata_next = offset_copy_reg;
    end
  end

  // Read data stand from the cycle after the strobe until the next cycle with clk_en high; they hold while clk_en is low
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      if (reg_read) begin
        reg_rdata <= DATA_W'(rdata_next);
      end else begin
        reg_rdata <= '0;
      end
    end
  end

  lane_pattern_gate u_lane7 (
    .choose      (per_lane_pattern_choose),                         // R03
    .code_in     (pattern_reg[`LANE7_PAT_MSB:`LANE7_PAT_LSB]),      // R01
    .code_out    (lane7_pattern_code),
    .code_active (lane7_pattern_active)
  );

  lane_pattern_gate u_lane8 (
    .choose      (per_lane_pattern_choose),                         // R03
    .code_in     (pattern_reg[`LANE8_PAT_MSB:`LANE8_PAT_LSB]),      // R02
    .code_out    (lane8_pattern_code),
    .code_active (lane8_pattern_active)
  );

  // Index 3 is channel/lane 8, index 0 is channel/lane 5
  assign digital_sleep = power_reg[`DIG_SLEEP_MSB:`DIG_SLEEP_LSB]; // R04
  assign output_sleep  = power_reg[`OUT_SLEEP_MSB:`OUT_SLEEP_LSB]; // R05
  assign analog_sleep  = power_reg[`ANA_SLEEP_MSB:`ANA_SLEEP_LSB]; // R06
  assign polarity_flip = power_reg[`FLIP_MSB:`FLIP_LSB];           // R07

  // Gain and offset outputs are zero while their global enable is off; the mismatch flag and register readback are not gated
  assign chan9_gain_code = global_gain_apply ?
      gain_offset_reg[`GAIN_MSB:`GAIN_LSB] : 5'h00; // R09
  // Ten bits: the top code of 31 gives 620 hundredths of a dB
  assign chan9_gain_centi_db = 10'(chan9_gain_code) *
      10'(`GAIN_STEP_CENTI_DB); // R10
  assign chan9_offset_value = global_offset_apply ?
      $signed(gain_offset_reg[`OFFSET_MSB:`OFFSET_LSB]) : 10'sh000; // R11 R12
  // Flags a software slip in keeping the two offset copies equal
  assign chan9_offset_mismatch =
      gain_offset_reg[`OFFSET_MSB:`OFFSET_LSB] !=
      offset_copy_reg[`OFFSET_MSB:`OFFSET_LSB]; // R14

endmodule : lane_test_power_gain_regs

//--- verification/lane_slice_assertions.sv
// Checker for the lane test, power and channel 9 gain register slice.
// Assumes it is bound to the slice top and sees only its ports.
`timescale 1ns/100ps
module lane_slice_chk (
  input logic        clk_sys,
  input logic        reset_n,
  input logic        clk_en,
  input logic [7:0]  reg_addr,
  input logic [15:0] reg_wdata,
  input logic        reg_write,
  input logic        reg_read,
  input logic [15:0] reg_rdata,
  input logic        per_lane_pattern_choose,
  input logic        global_gain_apply,
  input logic [2:0]  lane7_pattern_code,
  input logic [3:0]  digital_sleep,
  input logic [3:0]  polarity_flip,
  input logic [4:0]  chan9_gain_code,
  input logic [9:0]  chan9_gain_centi_db,
  input logic        global_offset_apply,
  input logic [2:0]  lane8_pattern_code,
  input logic [3:0]  output_sleep,
  input logic [3:0]  analog_sleep,
  input logic [9:0]  chan9_offset_value
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire w23 = reg_write && clk_en && reg_addr == 8'h23;
  wire w24 = reg_write && clk_en && reg_addr == 8'h24;
  wire w25 = reg_write && clk_en && reg_addr == 8'h25;
  pat_off_a: assert property (!per_lane_pattern_choose |->
    lane7_pattern_code == 3'h0) else $error("lane 7 code leaks");
  pat_load_a: assert property (w23 ##1 per_lane_pattern_choose |->
    lane7_pattern_code == $past(reg_wdata[7:5])) else $error("lane 7 code");
  dig_load_a: assert property (w24 |=>
    digital_sleep == $past(reg_wdata[15:12])) else $error("digital sleep");
  flip_load_a: assert property (w24 |=>
    polarity_flip == $past(reg_wdata[3:0])) else $error("flip load");
  flip_hold_a: assert property (!w24 |=> $stable(polarity_flip))
    else $error("flip changed without write");
  gain_load_a: assert property (w25 ##1 global_gain_apply |->
    chan9_gain_code == $past(reg_wdata[15:11])) else $error("gain load");
  gain_off_a: assert property (!global_gain_apply |->
    chan9_gain_code == 5'h00) else $error("gain shown while off");
  gain_step_a: assert property (chan9_gain_centi_db ==
    10'(chan9_gain_code) * 10'h014) else $error("gain step");
  rd_flip_a: assert property (reg_read && clk_en && reg_addr == 8'h24 |=>
    reg_rdata[3:0] == polarity_flip) else $error("flip readback");
  pat8_load_a: assert property (w23 ##1 per_lane_pattern_choose |->
    lane8_pattern_code == $past(reg_wdata[4:2])) else $error("lane 8 code");
  out_load_a: assert property (w24 |=>
    output_sleep == $past(reg_wdata[11:8])) else $error("output sleep");
  ana_load_a: assert property (w24 |=>
    analog_sleep == $past(reg_wdata[7:4])) else $error("analog sleep");
  offset_off_a: assert property (!global_offset_apply |->
    chan9_offset_value == 10'h000) else $error("offset shown while off");
  offset_load_a: assert property (w25 ##1 global_offset_apply |->
    chan9_offset_value == $past(reg_wdata[9:0])) else $error("offset load");
endmodule : lane_slice_chk

//--- verification/tb_top.sv
// Self-checking bench for the lane test, power and gain register slice.
// Drives the register port at 40 MHz; expectations come from the rules.
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
  import lane_test_power_gain_pkg::*;
  typedef struct {logic [7:0] a; logic [15:0] d, e;} row_t;
  logic clk_sys = 0, reset_n = 0, clk_en = 1, reg_write = 0, reg_read = 0;
  logic per_lane_pattern_choose = 1, global_gain_apply = 1;
  logic global_offset_apply = 1, lane7_pattern_active, lane8_pattern_active;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  pattern_code_t lane7_pattern_code, lane8_pattern_code;
  lane_vec_t digital_sleep, output_sleep, analog_sleep, polarity_flip;
  gain_code_t chan9_gain_code;
  logic [9:0] chan9_gain_centi_db;
  offset_t chan9_offset_value;
  logic chan9_offset_mismatch;
  int failures = 0, n_compared = 0;
  // Same offset into both places, reserved bit 15 set, two unmapped
  row_t rows [6] = '{'{8'h23, 16'h8074, 16'h8074},
    '{8'h24, 16'hA5C3, 16'hA5C3}, '{8'h25, 16'hB3F0, 16'hB3F0},
    '{8'h26, 16'h03F0, 16'h03F0}, '{8'h22, 16'hFFFF, 16'h0000},
    '{8'h27, 16'hFFFF, 16'h0000}};
  lane_test_power_gain_regs DUT (.*);
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 `CHK("readback", e, reg_rdata)
  endtask : rdc
  task automatic final_report;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial forever #12.5 clk_sys = ~clk_sys;
  // Whole run is under 60 cycles; this is far beyond it
  initial begin
    #100us;
    failures++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) rdc(8'(8'h23 + i), 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    `CHK("lane7", 3'h3, lane7_pattern_code)
    `CHK("lane8", 3'h5, lane8_pattern_code)
    `CHK("digital", 4'hA, digital_sleep)
    `CHK("output", 4'h5, output_sleep)
    `CHK("analog", 4'hC, analog_sleep)
    `CHK("flip", 4'h3, polarity_flip)
    `CHK("gain", 5'h16, chan9_gain_code)
    `CHK("centi", 10'h1B8, chan9_gain_centi_db)
    `CHK("offset", 10'h3F0, chan9_offset_value)
    `CHK("sign", 1'b1, chan9_offset_value < 0)
    `CHK("match", 1'b0, chan9_offset_mismatch)
    `CHK("active", 2'h3, {lane7_pattern_active, lane8_pattern_active})
    @(posedge clk_sys);
    per_lane_pattern_choose <= 1'b0;
    global_gain_apply <= 1'b0;
    global_offset_apply <= 1'b0;
    clk_en <= 1'b0;
    wr(8'h24, 16'h0000);
    clk_en <= 1'b1;
    #1 `CHK("gated", 21'h0, {lane7_pattern_code, lane8_pattern_code, chan9_gain_code, chan9_offset_value})
    `CHK("frozen", 4'h3, polarity_flip)
    `CHK("idle", 2'h0, {lane7_pattern_active, lane8_pattern_active})
    wr(8'h26, 16'h0001);
    #1 `CHK("mismatch", 1'b1, chan9_offset_mismatch)
    // Top gain code: 31 steps must not wrap the centi-dB output
    @(posedge clk_sys);
    global_gain_apply <= 1'b1;
    wr(8'h25, 16'hF800);
    #1 `CHK("gain max", 5'h1F, chan9_gain_code)
    `CHK("centi max", 10'h26C, chan9_gain_centi_db)
    @(posedge clk_sys);
    reset_n <= 1'b0;
    @(posedge clk_sys);
    #1 `CHK("reset", 16'h0, {digital_sleep, output_sleep, analog_sleep, polarity_flip})
    final_report;
  end
endmodule : tb_top
bind lane_test_power_gain_regs lane_slice_chk chk (.*);
